// file: include/sbc_mode_pkg.sv
// Functional notes
// RULE_01: header address 00 selects mode word; bit 13 picks diagnosis or status.
// RULE_02: read-only flag set returns feedback and leaves mode word untouched.
// RULE_03: read-only flag clear returns feedback and loads the data bits.
// RULE_04: development flag 0 keeps normal supervision; 1 enters development mode.
// RULE_05: controller always writes bit 0 of the mode word as zero.
// RULE_06: flash entry only via normal, flash, normal, flash serving writes.
// RULE_07: final write of that order forces a system reset, then start-up.
// RULE_08: forced flash-entry reset records its own code in reset-source field.
// RULE_09: after that reset, writing 011 in initial window enters flash mode.
// RULE_10: with prescaler 00 the six-bit period code decodes to per-mode periods.
// RULE_11: mode field codes 001..111 decode to their seven mode commands.
// RULE_12: global enable pin follows bit 1 of the mode word.
package sbc_mode_pkg;
  localparam int          FRAME_BITS     = 16;
  localparam int          HDR_ADDR_LO    = 14;
  localparam int          HDR_SEL_BIT    = 13;
  localparam int          HDR_RO_BIT     = 12;
  localparam int          DATA_BITS      = 12;
  localparam logic [1:0]  ADDR_MODE      = 2'h0;
  localparam logic [1:0]  PRESCALE_BASE  = 2'h0;
  localparam logic [11:0] CTRL_RESET     = 12'h000;
  localparam logic [3:0]  RSS_NONE       = 4'h0;
  localparam logic [3:0]  RSS_FLASH_SEQ  = 4'h5;
  localparam logic [15:0] WD_OFF         = 16'h0000;

  typedef enum logic [2:0] {
    MODE_NONE        = 3'h0,
    MODE_NORMAL      = 3'h1,
    MODE_STANDBY     = 3'h2,
    MODE_INIT_FLASH  = 3'h3,
    MODE_SLEEP       = 3'h4,
    MODE_INIT_NORMAL = 3'h5,
    MODE_LEAVE_FLASH = 3'h6,
    MODE_FLASH       = 3'h7
  } mode_cmd_t;

  typedef struct packed {
    logic [5:0] period;
    mode_cmd_t  mode;
    logic       dev_mode;
    logic       enable;
    logic       reserved;
  } ctrl_word_t;

  typedef struct packed {
    logic [15:0] normal;
    logic [15:0] standby;
    logic [15:0] flash;
    logic [15:0] sleep;
  } wd_periods_t;

  typedef struct packed {
    logic        valid;
    wd_periods_t ms;
  } period_dec_t;

  // period code to milliseconds per mode, base prescaler only
  function automatic period_dec_t period_decode(input logic [5:0] code);
    period_dec_t r;
    r = '0;
    r.valid = 1'b1;
    case (code)
      6'h09: r.ms = {16'h0004, 16'h0014, 16'h0014, 16'h00a0};
      6'h0c: r.ms = {16'h0008, 16'h0028, 16'h0028, 16'h0140};
      6'h12: r.ms = {16'h0010, 16'h0050, 16'h0050, 16'h0280};
      6'h14: r.ms = {16'h0020, 16'h00a0, 16'h00a0, 16'h0400};
      6'h1b: r.ms = {16'h0028, 16'h0140, 16'h0140, 16'h0800};
      6'h24: r.ms = {16'h0030, 16'h0280, 16'h0280, 16'h0c00};
      6'h2d: r.ms = {16'h0038, 16'h0400, 16'h0400, 16'h1000};
      6'h33: r.ms = {16'h0040, 16'h0800, 16'h0800, 16'h1800};
      6'h35: r.ms = {16'h0048, 16'h1000, 16'h1000, 16'h2000};
      6'h36: r.ms = {16'h0050, WD_OFF, 16'h2000, WD_OFF};
      default: r.valid = 1'b0;
    endcase
    return r;
  endfunction
endpackage

// file: src/sbc_mode_watchdog_register.sv
`timescale 1ns/1ps
module sbc_mode_watchdog_register (
  // system clock and reset
  input  wire logic                     i_sys_clk,
  input  wire logic                     i_resetn,
  // serial link pins
  input  wire logic                     i_sck,
  input  wire logic                     i_scs_n,
  input  wire logic                     i_sdi,
  output logic                          o_sdo,
  output logic                          o_sdo_oe,
  // feedback words from neighbouring blocks
  input  wire logic [11:0]              i_status_word,
  input  wire logic [11:0]              i_diag_word,
  // watchdog engine handshakes
  input  wire logic                     i_trigger_ok,
  input  wire logic                     i_init_window,
  input  wire logic [1:0]               i_wd_prescaler,
  // decoded controls
  output logic                          o_enable,
  output logic                          o_dev_mode,
  output sbc_mode_pkg::mode_cmd_t       o_mode_cmd,
  output logic                          o_mode_strobe,
  output sbc_mode_pkg::wd_periods_t     o_wd_periods,
  output logic                          o_period_valid,
  output logic                          o_force_reset,
  output logic [3:0]                    o_reset_source,
  output logic                          o_flash_active
);
  import sbc_mode_pkg::*;

  typedef enum logic [3:0] {
    SEQ_IDLE = 4'b0001,
    SEQ_N1   = 4'b0010,
    SEQ_F1   = 4'b0100,
    SEQ_N2   = 4'b1000
  } seq_t;

  // ---------------- link domain ----------------
  logic [4:0]  bit_cnt_q;
  logic [15:0] rx_q;
  logic        full_q;
  logic        over_q;
  logic        sel_q;
  logic        sdo_q;
  logic [11:0] fb_stat_q;
  logic [11:0] fb_diag_q;
  logic [11:0] fb_sel;

  // sample on falling edge; scs high clears the bit counter
  always_ff @(negedge i_sck or posedge i_scs_n) begin
    if (i_scs_n) begin
      bit_cnt_q <= 5'h00;
    end else if (bit_cnt_q != 5'(FRAME_BITS)) begin
      bit_cnt_q <= bit_cnt_q + 5'h01; // holds at 16 on a long frame
    end
  end

  // result flags are levels, not toggles: they need no reset and
  // outlive chip select so the system side can judge the frame
  always_ff @(negedge i_sck) begin
    if (bit_cnt_q < 5'(FRAME_BITS)) begin
      rx_q <= {rx_q[14:0], i_sdi};
    end
    if (bit_cnt_q == 5'(FRAME_BITS - 1 - HDR_SEL_BIT)) begin
      sel_q <= i_sdi; // feedback select held for the whole frame
    end
    full_q <= (bit_cnt_q == 5'(FRAME_BITS - 1)); // exactly 16 edges
    over_q <= (bit_cnt_q == 5'(FRAME_BITS));     // 17 edges or more
  end

  // select latched once; rx_q keeps shifting while data goes out
  always_comb begin
    fb_sel = sel_q ? fb_diag_q : fb_stat_q; // see RULE_01
  end

  // shift out on rising edge; header slots read as zero
  always_ff @(posedge i_sck or posedge i_scs_n) begin
    if (i_scs_n) begin
      sdo_q <= 1'b0;
    end else if (bit_cnt_q >= 5'(FRAME_BITS - DATA_BITS) &&
                 bit_cnt_q < 5'(FRAME_BITS)) begin
      sdo_q <= fb_sel[4'(FRAME_BITS - 1) - bit_cnt_q[3:0]];
    end else begin
      sdo_q <= 1'b0;
    end
  end

  assign o_sdo    = sdo_q;
  assign o_sdo_oe = ~i_scs_n;

  // ---------------- system domain ----------------
  logic [2:0] sync_d [3];
  logic [2:0] sync_q [3];
  logic [2:0] lvl_d, lvl_q;
  logic [11:0] stat_d, diag_d;
  ctrl_word_t  ctrl_d, ctrl_q;
  seq_t        seq_d, seq_q;
  logic        armed_d, armed_q;
  logic        flash_d, flash_q;
  logic        strobe_d, strobe_q;
  logic        force_d, force_q;
  logic [3:0]  rss_d, rss_q;
  logic        frame_end, accept, wr, ro, legal;
  ctrl_word_t  wdata;
  period_dec_t dec_new, dec_cur;

  // three stages each for scs, completion flag, overrun flag
  always_comb begin
    sync_d[0] = {i_scs_n, full_q, over_q};
    sync_d[1] = sync_q[0];
    sync_d[2] = sync_q[1];
    for (int k = 0; k < 3; k++) begin
      lvl_d[k] = (sync_q[1][k] == sync_q[2][k]) ? sync_q[2][k] : lvl_q[k];
    end
  end

  always_ff @(posedge i_sys_clk) begin
    sync_q <= sync_d;
    if (!i_resetn) begin
      lvl_q <= 3'h4;
    end else begin
      lvl_q <= lvl_d;
    end
  end

  // frame judged once chip select is back high and link is quiet
  always_comb begin
    frame_end = lvl_d[2] & ~lvl_q[2];
    accept    = frame_end & lvl_d[1] & ~lvl_d[0];
    wdata     = ctrl_word_t'(rx_q[11:0]);
    wr        = accept & (rx_q[15:HDR_ADDR_LO] == ADDR_MODE); // see RULE_01
    ro        = rx_q[HDR_RO_BIT];
    dec_new   = period_decode(wdata.period);
    legal     = dec_new.valid & (wdata.mode != MODE_NONE);
    // snapshot feedback only while no frame can be reading it
    stat_d    = (lvl_q[2] & sync_q[1][2]) ? i_status_word : fb_stat_q;
    diag_d    = (lvl_q[2] & sync_q[1][2]) ? i_diag_word : fb_diag_q;
  end

  // mode word, flash entry order and reset-source capture
  always_comb begin
    ctrl_d   = ctrl_q;
    seq_d    = seq_q;
    armed_d  = armed_q & i_init_window;
    flash_d  = flash_q;
    strobe_d = 1'b0;
    force_d  = 1'b0;
    rss_d    = rss_q;
    if (wr && !ro) begin // see RULE_02
      if (!legal) begin
        force_d = 1'b1; // illegal coding: ignore and reset
        seq_d   = SEQ_IDLE;
      end else begin
        ctrl_d   = wdata; // see RULE_03
        strobe_d = 1'b1;
        case (seq_q) // see RULE_06
          SEQ_IDLE: seq_d = (wdata.mode == MODE_NORMAL && i_trigger_ok)
                            ? SEQ_N1 : SEQ_IDLE;
          SEQ_N1:   seq_d = (wdata.mode == MODE_FLASH && i_trigger_ok)
                            ? SEQ_F1 : SEQ_IDLE;
          SEQ_F1:   seq_d = (wdata.mode == MODE_NORMAL && i_trigger_ok)
                            ? SEQ_N2 : SEQ_IDLE;
          SEQ_N2:   seq_d = SEQ_IDLE;
          default:  seq_d = SEQ_IDLE;
        endcase
        if (seq_q == SEQ_N2 && wdata.mode == MODE_FLASH && i_trigger_ok) begin
          force_d  = 1'b1; // see RULE_07
          ctrl_d   = ctrl_word_t'(CTRL_RESET);
          strobe_d = 1'b0;
          rss_d    = RSS_FLASH_SEQ; // see RULE_08
          armed_d  = 1'b1;
        end
        if (wdata.mode == MODE_INIT_FLASH && armed_q && i_init_window) begin
          flash_d = 1'b1; // see RULE_09
          armed_d = 1'b0;
        end
        if (wdata.mode == MODE_LEAVE_FLASH) begin
          flash_d = 1'b0;
        end
      end
    end
  end

  always_ff @(posedge i_sys_clk) begin
    fb_stat_q <= stat_d;
    fb_diag_q <= diag_d;
    if (!i_resetn) begin
      ctrl_q     <= ctrl_word_t'(CTRL_RESET);
      seq_q      <= SEQ_IDLE;
      armed_q    <= 1'b0;
      flash_q    <= 1'b0;
      strobe_q   <= 1'b0;
      force_q    <= 1'b0;
      rss_q      <= RSS_NONE;
    end else begin
      ctrl_q     <= ctrl_d;
      seq_q      <= seq_d;
      armed_q    <= armed_d;
      flash_q    <= flash_d;
      strobe_q   <= strobe_d;
      force_q    <= force_d;
      rss_q      <= rss_d;
    end
  end

  // decoded outputs; other prescalers are left to the timing engine
  always_comb begin
    dec_cur        = period_decode(ctrl_q.period); // see RULE_10
    o_wd_periods   = dec_cur.ms;
    o_period_valid = dec_cur.valid & (i_wd_prescaler == PRESCALE_BASE);
  end

  assign o_enable       = ctrl_q.enable;   // see RULE_12
  assign o_dev_mode     = ctrl_q.dev_mode; // see RULE_04
  assign o_mode_cmd     = ctrl_q.mode;     // see RULE_11
  assign o_mode_strobe  = strobe_q;
  assign o_force_reset  = force_q;
  assign o_reset_source = rss_q;
  assign o_flash_active = flash_q;

  // ---------------- checks ----------------
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (!i_resetn);

  ro_keeps_word_a: assert property (wr && ro |=> $stable(ctrl_q)) // see RULE_02
    else $error("read-only frame changed mode word");
  addr_other_a: assert property (accept && !wr |=> $stable(ctrl_q)) // see RULE_01
    else $error("foreign address changed mode word");
  write_loads_a: assert property (wr && !ro && legal && !force_d
      |=> ctrl_q == $past(wdata)) // see RULE_03
    else $error("legal write not loaded");
  enable_pin_a: assert property (wr && !ro && legal && !force_d
      |=> o_enable == $past(wdata.enable)) // see RULE_12
    else $error("enable pin not following bit 1");
  dev_mode_a: assert property (wr && !ro && legal && !force_d
      |=> o_dev_mode == $past(wdata.dev_mode)) // see RULE_04
    else $error("development mode output wrong");
  flash_force_a: assert property ($rose(o_reset_source == RSS_FLASH_SEQ)
      |-> o_force_reset && $past(seq_q) == SEQ_N2) // see RULE_07
    else $error("flash order reset missing");
  rss_code_a: assert property (force_q && $past(seq_q) == SEQ_N2
      && $past(wdata.mode) == MODE_FLASH && $past(wr)
      && $past(legal) && $past(i_trigger_ok)
      |-> o_reset_source == RSS_FLASH_SEQ) // see RULE_08
    else $error("reset source not recorded");
  flash_armed_a: assert property ($rose(o_flash_active)
      |-> $past(armed_q) && $past(wdata.mode) == MODE_INIT_FLASH) // see RULE_09
    else $error("flash entered without order");
  seq_order_a: assert property (seq_q == SEQ_F1
      |-> $past(seq_q) inside {SEQ_N1, SEQ_F1}) // see RULE_06
    else $error("flash order skipped a step");
  period_map_a: assert property (ctrl_q.period == 6'h36
      |-> o_wd_periods.flash == 16'h2000 && o_wd_periods.sleep == WD_OFF
      && o_wd_periods.normal == 16'h0050) // see RULE_10
    else $error("period decode wrong");
  mode_strobe_a: assert property (o_mode_strobe
      |-> o_mode_cmd == $past(wdata.mode)) // see RULE_11
    else $error("mode command not the written one");

  write_c: cover property (wr && !ro && legal);
  ro_read_c: cover property (wr && ro);
  flash_reset_c: cover property (force_q && rss_q == RSS_FLASH_SEQ);
  flash_on_c: cover property ($rose(o_flash_active));
endmodule

// file: verif/mcu_spi_master.sv
`timescale 1ns/1ps
// microcontroller in the master role on the serial link
module mcu_spi_master (
  // link pins
  output logic      o_sck,
  output logic      o_scs_n,
  output logic      o_sdi,
  input  wire logic i_sdo
);
  // link idles with clock low and select high
  initial begin
    o_sck   = 1'b0;
    o_scs_n = 1'b1;
    o_sdi   = 1'b0;
  end

  // n clocks; sdi moves on rising, sdo taken on falling
  task automatic frame(input logic [15:0] tx, input int n,
                       output logic [15:0] rx);
    rx = 16'h0000;
    o_scs_n = 1'b0;
    #30;
    for (int i = 0; i < n; i++) begin
      o_sck = 1'b1;
      o_sdi = tx[15 - (i % 16)];
      #7.5;
      o_sck = 1'b0;
      rx = {rx[14:0], i_sdo};
      #7.5;
    end
    #10;
    o_scs_n = 1'b1;
    o_sdi   = ~o_sdi; // released line must not keep the last bit
    #300;             // gap well beyond six system cycles
  endtask
endmodule

// file: verif/testbench.sv
`timescale 1ns/1ps
module testbench;
  import sbc_mode_pkg::*;
  logic        sys_clk, resetn, trig_ok, init_win, en, dev, strb, frc;
  logic        per_ok, fl_act, sdo, sdo_oe;
  logic [11:0] stat_w, diag_w;
  logic [1:0]  presc;
  logic [3:0]  rsrc;
  logic [15:0] rx;
  wire logic   sck, scs_n, sdi, sdo_w;
  mode_cmd_t   mode;
  wd_periods_t per;
  mode_cmd_t   ml[3] = '{MODE_SLEEP, MODE_INIT_NORMAL, MODE_LEAVE_FLASH};
  logic [2:0]  fo[7] = '{3'h1, 3'h7, 3'h2, 3'h1, 3'h7, 3'h1, 3'h7};
  int          n_errors = 0, cmp_count = 0, n_strb = 0, n_frc = 0;

  assign sdo_w = sdo_oe ? sdo : 1'bz; // floating outside frames

  sbc_mode_watchdog_register dut_u (
    .i_sys_clk(sys_clk), .i_resetn(resetn), .i_sck(sck),
    .i_scs_n(scs_n), .i_sdi(sdi), .o_sdo(sdo), .o_sdo_oe(sdo_oe),
    .i_status_word(stat_w), .i_diag_word(diag_w),
    .i_trigger_ok(trig_ok), .i_init_window(init_win),
    .i_wd_prescaler(presc), .o_enable(en), .o_dev_mode(dev),
    .o_mode_cmd(mode), .o_mode_strobe(strb), .o_wd_periods(per),
    .o_period_valid(per_ok), .o_force_reset(frc),
    .o_reset_source(rsrc), .o_flash_active(fl_act));

  mcu_spi_master mcu_u (
    .o_sck(sck), .o_scs_n(scs_n), .o_sdi(sdi), .i_sdo(sdo_w));

  initial sys_clk = 1'b0;
  always #10 sys_clk = ~sys_clk;

  // one-cycle pulses are counted, not sampled
  always @(posedge sys_clk) begin
    if (strb === 1'b1) n_strb++;
    if (frc === 1'b1) n_frc++;
  end

  task automatic stop_test;
    if (n_errors == 0 && cmp_count > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_errors++;
      $display("unexpected at %0t: got %h exp %h", $time, got, exp);
    end
  endtask

  function automatic logic [15:0] wd(input logic ro, sel,
      input logic [5:0] p, input logic [2:0] m, input logic dv, e);
    return {2'b00, sel, ro, p, m, dv, e, 1'b0};
  endfunction

  // frame, feedback check on full mode-word frames, then settle
  task automatic xfer(input logic [15:0] w, input int n = 16);
    mcu_u.frame(w, n, rx);
    if (n == 16 && w[15:14] == 2'b00)
      chk(rx, {4'h0, w[13] ? diag_w : stat_w});
    repeat (2) @(negedge sys_clk);
  endtask

  initial begin
    #100us;
    n_errors++;
    stop_test();
  end

  initial begin
    resetn = 1'b0; trig_ok = 1'b1; init_win = 1'b0; presc = 2'h0;
    stat_w = 12'h5a3; diag_w = 12'hc3c;
    repeat (6) @(negedge sys_clk);
    resetn = 1'b1;
    repeat (6) @(negedge sys_clk);
    chk({en, dev, mode, rsrc, fl_act, per_ok, sdo_oe}, '0);
    xfer(wd(1, 0, 6'h09, 3'h1, 1, 1));
    xfer(wd(1, 1, 6'h09, 3'h1, 1, 1));
    chk({n_strb, en, dev, mode}, '0);
    xfer(wd(0, 1, 6'h09, 3'h1, 1, 1));
    chk({en, dev, mode, per_ok}, {2'b11, MODE_NORMAL, 1'b1});
    chk(per, {16'h0004, 16'h0014, 16'h0014, 16'h00a0});
    xfer(wd(0, 0, 6'h36, 3'h2, 0, 0));
    chk(per, {16'h0050, 16'h0000, 16'h2000, 16'h0000});
    chk({en, dev, mode}, {2'b00, MODE_STANDBY});
    for (int i = 0; i < 3; i++) begin
      xfer(wd(0, 0, 6'h09, ml[i], 0, 1));
      chk(mode, ml[i]);
    end
    // prescaler other than base invalidates the decode
    @(negedge sys_clk) presc = 2'h1;
    repeat (3) @(negedge sys_clk);
    chk(per_ok, 1'b0);
    presc = 2'h0;
    // short frame and foreign address leave the word alone
    xfer(wd(0, 0, 6'h12, 3'h1, 1, 0), 15);
    xfer(wd(0, 0, 6'h12, 3'h1, 1, 0) | 16'h4000);
    chk({n_strb, mode, dev}, {32'd5, MODE_LEAVE_FLASH, 1'b0});
    xfer(wd(0, 0, 6'h00, 3'h1, 0, 1));
    chk({n_frc, mode}, {32'd1, MODE_LEAVE_FLASH});
    // window already open when the order's reset lands
    init_win = 1'b1;
    // broken order first, then the full order
    for (int i = 0; i < 7; i++) begin
      xfer(wd(0, 0, 6'h09, fo[i], 0, 1));
      chk(n_frc, (i == 6) ? 2 : 1);
    end
    chk({en, mode}, {1'b0, MODE_NONE});
    chk(rsrc, RSS_FLASH_SEQ);
    xfer(wd(0, 0, 6'h36, 3'h3, 0, 0));
    chk(fl_act, 1'b1);
    xfer(wd(0, 0, 6'h36, 3'h6, 0, 0));
    chk(fl_act, 1'b0);
    // last step without a valid trigger must not finish the order
    for (int i = 0; i < 4; i++) begin
      trig_ok = (i < 3);
      xfer(wd(0, 0, 6'h09, fo[i + 3], 0, 1));
    end
    chk({n_frc, mode}, {32'd2, MODE_FLASH});
    stop_test();
  end
endmodule
